//--- shared/ext_port_pkg.sv
// constants and types for the external memory port pin logic
package ext_port_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 24;
   localparam int ATTR_N = 4;
   localparam int MODE_W = 16;
   localparam int ATTR_PRIORITY_OFF_BIT = 14;
   localparam int WAIT_W = 4;
   localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0_0000;
   localparam logic [DATA_W-1:0] DATA_RST = 24'h00_0000;
   localparam logic [ATTR_N-1:0] ATTR_RST = 4'h0;
   localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;
   localparam logic [WAIT_W-1:0] WAIT_ONE = 4'h1;
   localparam int CLK_MHZ = 50;
   localparam int DRAM_MAX_MHZ = 100;
   typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_HOLD} port_state_t;
endpackage

//--- hdl/external_memory_port_pins.sv
// external memory port pin driver: address, data, attribute/row strobes, read and write
// Operation
// RL1: stop or wait releases mastership and floats all port pins.
// RL2: drive 18-bit address while master, float otherwise.
// RL3: address holds previous value when no external access occurs.
// RL4: drive 24-bit data bus while master for writes, float otherwise.
// RL5: keepers hold last driven data; data input ignored in reset.
// RL6: each attribute line serves as chip select or extra address.
// RL7: by default priority lets only one attribute line assert.
// RL8: priority-off bit 14 of mode register lets all four assert.
// RL9: row strobe mode gives floatable outputs with programmable polarity.
// RL10: row strobe mode only used at 100 MHz or lower.
// RL11: active-low read strobe while master, floated otherwise.
// RL12: active-low write strobe while master, floated otherwise.
// RL13: zero wait-state access ignores transfer acknowledge.
// RL14: per-pin setting selects attribute or row strobe function.
// RL15: memory drives data only while read strobe is asserted.
module external_memory_port_pins
   import ext_port_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   // core access request
   input wire logic i_req,
   input wire logic i_req_write,
   input wire logic [ext_port_pkg::ADDR_W-1:0] i_req_addr,
   input wire logic [ext_port_pkg::DATA_W-1:0] i_req_wdata,
   input wire logic [ext_port_pkg::ATTR_N-1:0] i_req_attr,
   input wire logic [ext_port_pkg::WAIT_W-1:0] i_req_waits,
   output logic o_req_ready,
   output logic o_done,
   output logic [ext_port_pkg::DATA_W-1:0] o_rdata,
   // mode and configuration
   input wire logic i_bus_master,
   input wire logic i_low_power,
   input wire logic [ext_port_pkg::MODE_W-1:0] i_operating_mode_reg,
   input wire logic [ext_port_pkg::ATTR_N-1:0] i_row_strobe_sel,
   input wire logic [ext_port_pkg::ATTR_N-1:0] i_row_strobe_pol,
   // external pins
   output logic [ext_port_pkg::ADDR_W-1:0] o_addr,
   output logic o_addr_oe,
   input wire logic [ext_port_pkg::DATA_W-1:0] i_data,
   output logic [ext_port_pkg::DATA_W-1:0] o_data,
   output logic o_data_oe,
   output logic [ext_port_pkg::ATTR_N-1:0] o_addr_attr_sel,
   output logic o_addr_attr_oe,
   output logic o_rd_n,
   output logic o_rd_oe,
   output logic o_wr_n,
   output logic o_wr_oe,
   input wire logic i_transfer_ack_n
);
   import ext_port_pkg::*;

   if (CLK_MHZ > DRAM_MAX_MHZ || ATTR_PRIORITY_OFF_BIT >= MODE_W) begin : g_cfg_check
      $error("clock too fast for row strobe mode or mode bit out of range"); // see RL10
   end

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] data_s1, data_s2;
   logic ack_s1, ack_s2;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         data_s1 <= DATA_RST; // see RL5
         data_s2 <= DATA_RST;
         ack_s1 <= 1'b1;
         ack_s2 <= 1'b1;
      end else begin
         data_s1 <= i_data;
         data_s2 <= data_s1;
         ack_s1 <= i_transfer_ack_n;
         ack_s2 <= ack_s1;
      end
   end

   // ----------------------------------------------------------------
   // attribute decode
   // ----------------------------------------------------------------
   function automatic logic [ATTR_N-1:0] prio_one(input logic [ATTR_N-1:0] a);
      logic [ATTR_N-1:0] r;
      r = '0;
      for (int k = ATTR_N - 1; k >= 0; k--) begin
         if (a[k]) begin
            r = '0;
            r[k] = 1'b1;
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // access sequencer
   // ----------------------------------------------------------------
   port_state_t state, next_state;
   logic [ADDR_W-1:0] addr, next_addr;
   logic [DATA_W-1:0] wdata, next_wdata, rdata, next_rdata;
   logic [ATTR_N-1:0] attr, next_attr;
   logic [WAIT_W-1:0] waits, next_waits;
   logic write, next_write, done, next_done, drive, next_drive;
   logic rd_n, next_rd_n, wr_n, next_wr_n, data_oe, next_data_oe;
   logic active;

   assign active = i_bus_master && !i_low_power; // see RL1

   always_comb begin
      next_state = state;
      next_addr = addr;
      next_wdata = wdata;
      next_rdata = rdata;
      next_attr = attr;
      next_waits = waits;
      next_write = write;
      next_done = 1'b0;
      next_drive = active;
      next_rd_n = 1'b1;
      next_wr_n = 1'b1;
      next_data_oe = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (active && i_req) begin
               next_state = ST_ACCESS;
               next_addr = i_req_addr; // see RL3
               next_wdata = i_req_write ? i_req_wdata : wdata; // see RL5
               next_write = i_req_write;
               next_waits = i_req_waits;
               if (i_operating_mode_reg[ATTR_PRIORITY_OFF_BIT]) begin
                  next_attr = i_req_attr; // see RL8
               end else begin
                  next_attr = prio_one(i_req_attr); // see RL7
               end
               next_rd_n = i_req_write; // see RL11
               next_wr_n = !i_req_write; // see RL12
               next_data_oe = i_req_write; // see RL4
            end
         end
         ST_ACCESS: begin
            next_rd_n = write;
            next_wr_n = !write;
            next_data_oe = write;
            if (!active) begin
               next_state = ST_IDLE;
               next_attr = ATTR_RST;
               next_rd_n = 1'b1;
               next_wr_n = 1'b1;
               next_data_oe = 1'b0;
            end else if (waits == WAIT_ZERO || (waits == WAIT_ONE && !ack_s2)) begin
               next_state = ST_HOLD; // see RL13
               next_rd_n = 1'b1;
               next_wr_n = 1'b1;
               next_rdata = write ? rdata : data_s2; // see RL15
            end else if (waits != WAIT_ONE) begin
               next_waits = waits - WAIT_ONE;
            end
         end
         ST_HOLD: begin
            next_state = ST_IDLE;
            next_done = 1'b1;
            next_attr = ATTR_RST;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= ST_IDLE;
         addr <= ADDR_RST;
         wdata <= DATA_RST;
         rdata <= DATA_RST;
         attr <= ATTR_RST;
         waits <= WAIT_ZERO;
         write <= 1'b0;
         done <= 1'b0;
         drive <= 1'b0;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         data_oe <= 1'b0;
      end else begin
         state <= next_state;
         addr <= next_addr;
         wdata <= next_wdata;
         rdata <= next_rdata;
         attr <= next_attr;
         waits <= next_waits;
         write <= next_write;
         done <= next_done;
         drive <= next_drive;
         rd_n <= next_rd_n;
         wr_n <= next_wr_n;
         data_oe <= next_data_oe;
      end
   end

   // ----------------------------------------------------------------
   // pin outputs
   // ----------------------------------------------------------------
   logic [ATTR_N-1:0] pin_attr, next_pin_attr;
   logic ready, next_ready;
   always_comb begin
      next_pin_attr = ATTR_RST;
      for (int k = 0; k < ATTR_N; k++) begin
         if (i_row_strobe_sel[k]) begin
            next_pin_attr[k] = next_attr[k] ~^ i_row_strobe_pol[k]; // see RL9 see RL14
         end else begin
            next_pin_attr[k] = next_attr[k]; // see RL6 see RL14
         end
      end
      next_ready = (next_state == ST_IDLE) && active;
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_attr <= ATTR_RST;
         ready <= 1'b0;
      end else begin
         pin_attr <= next_pin_attr;
         ready <= next_ready;
      end
   end

   assign o_addr = addr; // see RL2
   assign o_addr_oe = drive; // see RL2
   assign o_data = wdata; // see RL5
   assign o_data_oe = data_oe; // see RL4
   assign o_addr_attr_sel = pin_attr;
   assign o_addr_attr_oe = drive; // see RL1
   assign o_rd_n = rd_n;
   assign o_rd_oe = drive; // see RL11
   assign o_wr_n = wr_n;
   assign o_wr_oe = drive; // see RL12
   assign o_done = done;
   assign o_rdata = rdata;
   assign o_req_ready = ready;
endmodule

//--- dv/port_monitor.sv
// assertions on the external port pins
module port_monitor import ext_port_pkg::*; (
   input wire logic i_sys_clk, i_arst_n, i_req, i_req_write, o_req_ready, o_done,
   input wire logic i_bus_master, i_low_power, o_addr_oe, o_data_oe, o_addr_attr_oe,
   input wire logic o_rd_n, o_rd_oe, o_wr_n, o_wr_oe,
   input wire logic [WAIT_W-1:0] i_req_waits,
   input wire logic [ATTR_N-1:0] i_req_attr, i_row_strobe_sel, o_addr_attr_sel,
   input wire logic [MODE_W-1:0] i_operating_mode_reg,
   input wire logic [ADDR_W-1:0] o_addr,
   input wire logic [DATA_W-1:0] o_data);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);
   wire logic prio_off = i_operating_mode_reg[ATTR_PRIORITY_OFF_BIT];
   wire logic plain = i_row_strobe_sel == ATTR_RST;
   sequence s_take(w);
      i_req && o_req_ready && i_req_waits == WAIT_ZERO && i_req_write == w;
   endsequence
   sequence s_rd;
      !o_rd_n ##1 o_rd_n ##1 o_done;
   endsequence
   sequence s_wr;
      !o_wr_n && o_data_oe ##1 o_wr_n ##1 o_done;
   endsequence
   property p_float;
      i_low_power |=> !(o_addr_oe | o_data_oe | o_rd_oe | o_wr_oe | o_addr_attr_oe);
   endproperty
   a_float: assert property (p_float) else $error("pins driven in low power");
   property p_addr_off;
      !i_bus_master |=> !o_addr_oe && !o_rd_oe;
   endproperty
   a_addr_off: assert property (p_addr_off) else $error("address driven without mastership");
   property p_addr_hold;
      $changed(o_addr) |-> !o_rd_n || !o_wr_n;
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved without access");
   property p_data_off;
      !i_bus_master |=> !o_data_oe && !o_wr_oe;
   endproperty
   a_data_off: assert property (p_data_off) else $error("data driven without mastership");
   property p_keep;
      $fell(o_data_oe) |-> $stable(o_data);
   endproperty
   a_keep: assert property (p_keep) else $error("data lost at release");
   property p_prio;
      !$past(prio_off) && $past(plain) |-> $onehot0(o_addr_attr_sel);
   endproperty
   a_prio: assert property (p_prio) else $error("two attribute lines active");
   property p_all;
      i_req && o_req_ready && prio_off && plain |=> o_addr_attr_sel == $past(i_req_attr);
   endproperty
   a_all: assert property (p_all) else $error("attribute lines not passed whole");
   property p_rd0;
      s_take(1'b0) |=> s_rd;
   endproperty
   a_rd0: assert property (p_rd0) else $error("zero wait read wrong");
   property p_wr0;
      s_take(1'b1) |=> s_wr;
   endproperty
   a_wr0: assert property (p_wr0) else $error("zero wait write wrong");
endmodule
bind external_memory_port_pins port_monitor u_mon (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_req(i_req),
   .i_req_write(i_req_write), .o_req_ready(o_req_ready), .o_done(o_done), .i_bus_master(i_bus_master),
   .i_low_power(i_low_power), .o_addr_oe(o_addr_oe), .o_data_oe(o_data_oe), .o_addr_attr_oe(o_addr_attr_oe),
   .o_rd_n(o_rd_n), .o_rd_oe(o_rd_oe), .o_wr_n(o_wr_n), .o_wr_oe(o_wr_oe), .i_req_waits(i_req_waits),
   .i_req_attr(i_req_attr), .i_row_strobe_sel(i_row_strobe_sel), .o_addr_attr_sel(o_addr_attr_sel),
   .i_operating_mode_reg(i_operating_mode_reg), .o_addr(o_addr), .o_data(o_data));

//--- dv/ext_mem_model.sv
// partner model: external memory behind the port
module ext_mem_model import ext_port_pkg::*; (
   input wire logic i_clk, i_rd_n, i_wr_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   output logic [DATA_W-1:0] o_bus);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DATA_W-1:0] mem [16];
   logic [DATA_W-1:0] junk = 24'h5a_5a5a;
   always @(posedge i_clk) begin
      junk <= ~junk;
      if (!i_wr_n) mem[i_addr[3:0]] <= i_wdata;
   end
   assign o_bus = !i_rd_n ? mem[i_addr[3:0]] : junk;
endmodule

//--- dv/tb_top.sv
// self-checking bench for the external memory port pins
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ext_port_pkg::*;
   logic i_sys_clk, i_arst_n, i_req, i_req_write, i_bus_master, i_low_power, i_transfer_ack_n;
   logic o_req_ready, o_done, o_addr_oe, o_data_oe, o_addr_attr_oe, o_rd_n, o_rd_oe, o_wr_n, o_wr_oe;
   logic [ADDR_W-1:0] i_req_addr, o_addr;
   logic [DATA_W-1:0] i_req_wdata, o_rdata, o_data, bus, lastw;
   logic [ATTR_N-1:0] i_req_attr, i_row_strobe_sel, i_row_strobe_pol, o_addr_attr_sel;
   logic [WAIT_W-1:0] i_req_waits;
   logic [MODE_W-1:0] i_operating_mode_reg;
   logic [DATA_W-1:0] shadow [16];
   wire logic [DATA_W-1:0] i_data = o_data_oe ? o_data : bus;
   int err_count = 0, checked = 0, seed = 32'h7a7c_b53c, i, j;
   external_memory_port_pins dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_req(i_req),
      .i_req_write(i_req_write), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata), .i_req_attr(i_req_attr),
      .i_req_waits(i_req_waits), .o_req_ready(o_req_ready), .o_done(o_done), .o_rdata(o_rdata),
      .i_bus_master(i_bus_master), .i_low_power(i_low_power), .i_operating_mode_reg(i_operating_mode_reg),
      .i_row_strobe_sel(i_row_strobe_sel), .i_row_strobe_pol(i_row_strobe_pol), .o_addr(o_addr),
      .o_addr_oe(o_addr_oe), .i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe),
      .o_addr_attr_sel(o_addr_attr_sel), .o_addr_attr_oe(o_addr_attr_oe), .o_rd_n(o_rd_n), .o_rd_oe(o_rd_oe),
      .o_wr_n(o_wr_n), .o_wr_oe(o_wr_oe), .i_transfer_ack_n(i_transfer_ack_n));
   ext_mem_model mem (.i_clk(i_sys_clk), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_addr(o_addr),
      .i_wdata(o_data), .o_bus(bus));
   function automatic logic [ADDR_W-1:0] slot_addr(int n);
      return 18'h3_fff0 + 18'(n);
   endfunction
   function automatic logic [ATTR_N-1:0] strobe_idle(logic [ATTR_N-1:0] sel, logic [ATTR_N-1:0] pol);
      return ~pol & sel;
   endfunction
   task automatic test_done;
      if (err_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      checked++;
      if (e !== s) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic acc(logic w, logic [ADDR_W-1:0] ad, logic [DATA_W-1:0] d, logic [WAIT_W-1:0] n);
      int k;
      {i_req_write, i_req_addr, i_req_wdata, i_req_waits} = {w, ad, d, n};
      i_req_attr = 4'($random(seed));
      i_transfer_ack_n = n != WAIT_ZERO ? 1'b0 : 1'($random(seed));
      if (w) lastw = d;
      for (k = 0; o_req_ready !== 1'b1; k++) begin
         if (k > 40) begin
            err_count++;
            test_done;
         end
         @(posedge i_sys_clk) #1;
      end
      i_req = 1'b1;
      @(posedge i_sys_clk) #1;
      i_req = 1'b0;
      for (k = 0; o_done !== 1'b1; k++) begin
         if (k > 40) begin
            err_count++;
            test_done;
         end
         @(posedge i_sys_clk) #1;
      end
   endtask
   initial begin
      i_sys_clk = 0;
      forever #10 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      {i_req, i_req_write, i_req_addr, i_req_wdata, i_req_attr, i_req_waits} = '0;
      {i_operating_mode_reg, i_row_strobe_sel, i_row_strobe_pol} = '0;
      {i_transfer_ack_n, i_bus_master, i_low_power, i_arst_n} = 4'b1100;
      repeat (4) @(posedge i_sys_clk);
      #1 i_arst_n = 1;
      for (i = 0; i < 16; i++) begin
         shadow[i] = 24'($random(seed));
         acc(1'b1, slot_addr(i), shadow[i], 4'($random(seed) & 3));
      end
      for (i = 0; i < 20; i++) begin
         j = i < 2 ? i * 15 : $random(seed) & 15;
         acc(1'b0, slot_addr(j), '0, 4'h3);
         chk("read data", shadow[j], o_rdata);
         chk("address", slot_addr(j), o_addr);
      end
      i_operating_mode_reg = 16'h4000;
      for (i = 0; i < 6; i++) acc(i[0], 18'(i), shadow[i], WAIT_ZERO);
      i_operating_mode_reg = '0;
      i_row_strobe_sel = 4'b0101;
      i_row_strobe_pol = 4'($random(seed));
      acc(1'b0, 18'h0_0001, '0, 4'h3);
      chk("row strobe idle", strobe_idle(4'b0101, i_row_strobe_pol), o_addr_attr_sel & 4'b0101);
      i_row_strobe_sel = '0;
      i_low_power = 1;
      repeat (2) @(posedge i_sys_clk) #1;
      chk("ready in low power", 0, o_req_ready);
      chk("data oe", 0, o_data_oe);
      chk("kept data", lastw, o_data);
      {i_low_power, i_bus_master} = 2'b00;
      repeat (2) @(posedge i_sys_clk) #1;
      chk("address oe", 0, o_addr_oe);
      i_bus_master = 1;
      acc(1'b0, slot_addr(5), '0, 4'h3);
      chk("read after regain", shadow[5], o_rdata);
      test_done;
   end
endmodule
